// *** src/aowr_top.sv ***
// Output-word readout of a 16-bit sampling converter.
// Assumes the quantizer, the host pins and the register port share core_clk.
//
// Summary of operation
// R1: Hold control high holds, low samples.
// R2: Result coded as 16-bit offset binary.
// R3: Below range gives zeros and clip.
// R4: Above range gives ones and clip.
// R5: Eight lines carry high or low byte.
// R6: Host selects byte, waits strobe, then latches.
`timescale 1ns/1ps
module aowr_top
    import aowr_pkg::*;
(
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Host converter pins
    input wire logic convert_cmd,
    input wire logic byte_sel_high,
    output logic [7:0] data_out,
    output logic data_strobe,
    output logic clip_out,
    output logic hold_ctrl,
    // Quantizer core
    input wire logic quant_valid,
    input wire logic signed [AOWR_RAW_W-1:0] quant_value,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    aowr_state_t state_q, state_d;
    logic hold_q, hold_d;
    logic [AOWR_CODE_W-1:0] result_q, result_d;
    logic clip_q, clip_d;
    logic strobe_q, strobe_d;
    logic [7:0] data_q, data_d;
    logic enable_q, enable_d;
    logic [AOWR_IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [AOWR_IRQ_W-1:0] irq_mask_q, irq_mask_d;
    logic irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;
    logic [AOWR_CODE_W-1:0] enc_code;
    logic enc_clip;
    logic sw_start;
    logic start_req;
    logic done_evt;
    logic [AOWR_IRQ_W-1:0] evt;
    logic [AOWR_IRQ_W-1:0] w1c;

    aowr_encoder u_encoder (
        .raw_value(quant_value),
        .code(enc_code),
        .clip(enc_clip)
    );

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    assign sw_start = reg_write && (reg_addr == AOWR_ADDR_CTRL)
        && reg_wdata[AOWR_CTRL_START_BIT];
    assign start_req = enable_q && (convert_cmd || sw_start);
    assign done_evt = (state_q == AOWR_ST_HOLD) && quant_valid;

    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        result_d = result_q;
        clip_d = clip_q;
        strobe_d = 1'b0;
        case (state_q)
            AOWR_ST_IDLE: begin
                // Requests while a conversion runs are ignored, not queued.
                if (start_req) begin
                    state_d = AOWR_ST_HOLD;
                    hold_d = 1'b1; // see R1
                end
            end
            AOWR_ST_HOLD: begin
                if (quant_valid) begin
                    state_d = AOWR_ST_DONE;
                    hold_d = 1'b0; // see R1
                    result_d = enc_code; // see R2
                    clip_d = enc_clip; // see R3 R4
                end
            end
            AOWR_ST_DONE: begin
                // Strobe only once the word is stable in the result register.
                strobe_d = 1'b1;
                state_d = AOWR_ST_IDLE;
            end
            default: begin
                state_d = AOWR_ST_IDLE;
                hold_d = 1'b0;
            end
        endcase
    end

    // Result and clip move on one edge, so the host never sees a mixed pair.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= AOWR_ST_IDLE;
            hold_q <= 1'b0;
            result_q <= AOWR_CODE_ZERO;
            clip_q <= 1'b0;
            strobe_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            hold_q <= hold_d;
            result_q <= result_d;
            clip_q <= clip_d;
            strobe_q <= strobe_d;
        end
    end

    // ------------------------------------------------------------------
    // Byte-multiplexed output lines
    // ------------------------------------------------------------------
    always_comb begin
        // Line n shows the high byte when selected, else the low byte.
        if (byte_sel_high) begin
            data_d = result_q[15:8]; // see R5 R6
        end else begin
            data_d = result_q[7:0]; // see R5 R6
        end
    end

    // The lines lag the select by one cycle; the host must allow for it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 8'h00;
        end else if (clk_en) begin
            data_q <= data_d;
        end
    end

    // ------------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------------
    assign evt = {done_evt && enc_clip, done_evt};
    assign w1c = (reg_write && (reg_addr == AOWR_ADDR_IRQ_STAT))
        ? reg_wdata[AOWR_IRQ_W-1:0] : '0;

    always_comb begin
        enable_d = enable_q;
        irq_mask_d = irq_mask_q;
        // A new event in the clearing cycle keeps its bit set.
        irq_stat_d = (irq_stat_q & ~w1c) | evt;
        if (reg_write) begin
            if (reg_addr == AOWR_ADDR_CTRL) begin
                enable_d = reg_wdata[AOWR_CTRL_ENABLE_BIT];
            end else if (reg_addr == AOWR_ADDR_IRQ_MASK) begin
                irq_mask_d = reg_wdata[AOWR_IRQ_W-1:0];
            end
        end
        // Built from the next status and mask, so a clear lowers irq on its edge.
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= AOWR_CTRL_ENABLE_RST;
            irq_stat_q <= '0;
            irq_mask_q <= AOWR_IRQ_MASK_RST;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            enable_q <= enable_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        // Reads have no side effects, so software may poll status freely.
        rdata_d = 32'h0000_0000;
        if (reg_read) begin
            if (reg_addr == AOWR_ADDR_CTRL) begin
                rdata_d[AOWR_CTRL_ENABLE_BIT] = enable_q;
            end else if (reg_addr == AOWR_ADDR_STATUS) begin
                rdata_d[AOWR_STATUS_HOLD_BIT] = hold_q;
                rdata_d[AOWR_STATUS_CLIP_BIT] = clip_q;
                rdata_d[AOWR_STATUS_STATE_LSB +: 2] = state_q;
            end else if (reg_addr == AOWR_ADDR_RESULT) begin
                rdata_d[AOWR_CODE_W-1:0] = result_q;
            end else if (reg_addr == AOWR_ADDR_IRQ_STAT) begin
                rdata_d[AOWR_IRQ_W-1:0] = irq_stat_q;
            end else if (reg_addr == AOWR_ADDR_IRQ_MASK) begin
                rdata_d[AOWR_IRQ_W-1:0] = irq_mask_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign data_out = data_q;
    assign data_strobe = strobe_q;
    assign clip_out = clip_q;
    assign hold_ctrl = hold_q;
    assign reg_rdata = rdata_q;
    assign irq = irq_q;

endmodule

// *** common/aowr_pkg.sv ***
// Package for the converter output-word readout block.
// Assumes a single 40 MHz core clock and a plain strobe register port.
package aowr_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] AOWR_ADDR_CTRL = 8'h00;
    localparam logic [7:0] AOWR_ADDR_STATUS = 8'h04;
    localparam logic [7:0] AOWR_ADDR_RESULT = 8'h08;
    localparam logic [7:0] AOWR_ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] AOWR_ADDR_IRQ_MASK = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int AOWR_CTRL_ENABLE_BIT = 0;
    localparam int AOWR_CTRL_START_BIT = 1;
    localparam int AOWR_IRQ_DONE_BIT = 0;
    localparam int AOWR_IRQ_CLIP_BIT = 1;
    localparam int AOWR_STATUS_HOLD_BIT = 0;
    localparam int AOWR_STATUS_CLIP_BIT = 1;
    localparam int AOWR_STATUS_STATE_LSB = 2;

    // ------------------------------------------------------------------
    // Widths, codes and reset values
    // ------------------------------------------------------------------
    localparam int AOWR_CODE_W = 16;
    localparam int AOWR_RAW_W = 18;
    localparam int AOWR_IRQ_W = 2;
    localparam logic [15:0] AOWR_CODE_ZERO = 16'h0000;
    localparam logic [15:0] AOWR_CODE_FULL = 16'hFFFF;
    localparam logic [15:0] AOWR_CODE_MID = 16'h8000;
    localparam logic signed [17:0] AOWR_RAW_MIN = -18'sd32768;
    localparam logic signed [17:0] AOWR_RAW_MAX = 18'sd32767;
    localparam logic AOWR_CTRL_ENABLE_RST = 1'b1;
    localparam logic [1:0] AOWR_IRQ_MASK_RST = 2'h0;

    // ------------------------------------------------------------------
    // Conversion sequencer states (Gray along idle, hold, done)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AOWR_ST_IDLE = 2'b00,
        AOWR_ST_HOLD = 2'b01,
        AOWR_ST_DONE = 2'b11
    } aowr_state_t;

endpackage

// *** src/aowr_encoder.sv ***
// Saturating offset-binary encoder for one converter result.
// Assumes a signed two's-complement quantizer value in LSB units.
`timescale 1ns/1ps
module aowr_encoder
    import aowr_pkg::*;
(
    // Quantizer value
    input wire logic signed [AOWR_RAW_W-1:0] raw_value,
    // Encoded result
    output logic [AOWR_CODE_W-1:0] code,
    output logic clip
);

    // ------------------------------------------------------------------
    // Encoding
    // ------------------------------------------------------------------
    always_comb begin
        if (raw_value < AOWR_RAW_MIN) begin
            code = AOWR_CODE_ZERO; // see R3
            clip = 1'b1;
        end else if (raw_value > AOWR_RAW_MAX) begin
            code = AOWR_CODE_FULL; // see R4
            clip = 1'b1;
        end else begin
            // Flipping the sign bit maps two's complement onto offset binary.
            code = raw_value[AOWR_CODE_W-1:0] ^ AOWR_CODE_MID; // see R2
            clip = 1'b0;
        end
    end

endmodule

// *** tb/aowr_checker.sv ***
// Port assertions for the converter output-word readout block.
// Assumes it is bound to aowr_top and shares its core_clk and rst_n.
`timescale 1ns/1ps
module aowr_checker
    import aowr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic byte_sel_high,
    input wire logic [7:0] data_out,
    input wire logic data_strobe,
    input wire logic clip_out,
    input wire logic hold_ctrl,
    input wire logic quant_valid,
    input wire logic signed [AOWR_RAW_W-1:0] quant_value
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_hold_end; $fell(hold_ctrl) |-> $past(quant_valid); endproperty
    a_hold_end: assert property (p_hold_end) else $error("hold ended early");
    property p_strobe; data_strobe |-> !$past(hold_ctrl) && $past(hold_ctrl, 2); endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not after hold");
    property p_in; $fell(hold_ctrl) && $past(quant_value) >= AOWR_RAW_MIN
        && $past(quant_value) <= AOWR_RAW_MAX |-> !clip_out; endproperty
    a_in: assert property (p_in) else $error("clip in range");
    property p_lo; $fell(hold_ctrl) && $past(quant_value) < AOWR_RAW_MIN |-> clip_out; endproperty
    a_lo: assert property (p_lo) else $error("no clip below range");
    property p_hi; $fell(hold_ctrl) && $past(quant_value) > AOWR_RAW_MAX |-> clip_out; endproperty
    a_hi: assert property (p_hi) else $error("no clip above range");
    // A settled select over an unchanged result must leave the lines still.
    property p_lines; !$fell(hold_ctrl) && $stable(byte_sel_high) |=> $stable(data_out);
    endproperty
    a_lines: assert property (p_lines) else $error("byte lines moved");
endmodule

bind aowr_top aowr_checker u_aowr_checker (.core_clk(core_clk), .rst_n(rst_n),
    .byte_sel_high(byte_sel_high), .data_out(data_out), .data_strobe(data_strobe),
    .clip_out(clip_out), .hold_ctrl(hold_ctrl), .quant_valid(quant_valid),
    .quant_value(quant_value));

// *** tb/aowr_host_model.sv ***
// Host model that reads each new result as a low and a high byte.
// Assumes select 0 shows the low byte and the lines follow one cycle later.
`timescale 1ns/1ps
module aowr_host_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic data_strobe,
    input wire logic [7:0] data_out,
    output logic byte_sel_high,
    output logic [15:0] word,
    output logic word_ok
);
    logic [1:0] step;
    // The high byte is taken two edges after the flip, since the lines lag.
    always @(posedge core_clk or negedge rst_n) begin
        word_ok <= 1'b0;
        if (!rst_n) begin
            step <= 2'h0;
            byte_sel_high <= 1'b0;
            word <= 16'h0000;
        end else if (data_strobe) begin
            word[7:0] <= data_out;
            byte_sel_high <= 1'b1;
            step <= 2'h1;
        end else if (step == 2'h1) begin
            step <= 2'h2;
        end else if (step == 2'h2) begin
            word[15:8] <= data_out;
            byte_sel_high <= 1'b0;
            word_ok <= 1'b1;
            step <= 2'h0;
        end
    end
endmodule

// *** tb/aowr_top_bench.sv ***
// Bench for the readout block with the host byte reader beside it.
// Assumes the checker binds itself to aowr_top.
`timescale 1ns/1ps
module aowr_top_bench
    import aowr_pkg::*;
;
    logic core_clk = 0, rst_n = 0, clk_en = 1, convert_cmd = 0, quant_valid = 0;
    logic reg_write = 0, reg_read = 0, byte_sel_high, data_strobe, clip_out, hold_ctrl, irq;
    logic signed [17:0] quant_value = 18'h00000;
    logic [7:0] reg_addr = 8'h00, data_out;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] word;
    logic word_ok;
    int miscompares = 0, num_checks = 0;
    logic [17:0] vin [9] = '{18'h37FFF, 18'h38000, 18'h38001, 18'h3C000, 18'h3FFFF,
        18'h00000, 18'h07FFE, 18'h07FFF, 18'h08000};
    logic [15:0] vcode [9] = '{16'h0000, 16'h0000, 16'h0001, 16'h4000, 16'h7FFF,
        16'h8000, 16'hFFFE, 16'hFFFF, 16'hFFFF};
    logic [8:0] vclip = 9'h101;
    aowr_top u_aowr_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .convert_cmd(convert_cmd), .byte_sel_high(byte_sel_high), .data_out(data_out),
        .data_strobe(data_strobe), .clip_out(clip_out), .hold_ctrl(hold_ctrl),
        .quant_valid(quant_valid), .quant_value(quant_value), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq(irq));
    aowr_host_model u_aowr_host_model (.core_clk(core_clk), .rst_n(rst_n),
        .data_strobe(data_strobe), .data_out(data_out), .byte_sel_high(byte_sel_high),
        .word(word), .word_ok(word_ok));
    initial forever #12.5 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
        chk(reg_rdata, e);
    endtask
    // The command stays up into hold, so a start during hold is also offered.
    task automatic conv(input logic [17:0] v, input logic sw);
        int n;
        n = 0;
        if (sw) begin
            wr(AOWR_ADDR_CTRL, 32'h3);
        end else begin
            convert_cmd <= 1'b1;
        end
        do @(posedge core_clk); while (hold_ctrl !== 1'b1 && ++n < 20);
        convert_cmd <= 1'b0;
        quant_value <= v;
        quant_valid <= 1'b1;
        @(posedge core_clk);
        chk(32'(hold_ctrl), 32'h1);
        quant_valid <= 1'b0;
        do @(posedge core_clk); while (word_ok !== 1'b1 && ++n < 40);
        chk(32'(word_ok), 32'h1);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        test_done;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        chk(32'({hold_ctrl, irq, data_out}), 32'h0);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            conv(vin[i], 1'b0);
            chk(32'(word), 32'(vcode[i]));
            chk(32'(clip_out), 32'(vclip[i]));
            $display("row %0d done", i);
        end
        rd(AOWR_ADDR_IRQ_STAT, 32'h3);
        chk(32'(irq), 32'h0);
        wr(AOWR_ADDR_IRQ_MASK, 32'h2);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        wr(AOWR_ADDR_IRQ_STAT, 32'h2);
        rd(AOWR_ADDR_IRQ_STAT, 32'h1);
        chk(32'(irq), 32'h0);
        conv(18'h37FFF, 1'b0);
        chk(32'(irq), 32'h1);
        rd(AOWR_ADDR_RESULT, 32'h0);
        wr(8'h14, 32'h5);
        rd(8'h14, 32'h0);
        rd(AOWR_ADDR_IRQ_MASK, 32'h2);
        $display("register tests done");
        // A frozen enable must drop the write and keep the interrupt level.
        clk_en <= 1'b0;
        wr(AOWR_ADDR_IRQ_MASK, 32'h0);
        clk_en <= 1'b1;
        rd(AOWR_ADDR_IRQ_MASK, 32'h2);
        chk(32'(irq), 32'h1);
        $display("enable test done");
        wr(AOWR_ADDR_CTRL, 32'h0);
        convert_cmd <= 1'b1;
        repeat (3) @(posedge core_clk);
        convert_cmd <= 1'b0;
        chk(32'(hold_ctrl), 32'h0);
        rd(AOWR_ADDR_CTRL, 32'h0);
        wr(AOWR_ADDR_CTRL, 32'h1);
        rd(AOWR_ADDR_CTRL, 32'h1);
        conv(18'h08000, 1'b1);
        chk(32'(word), 32'hFFFF);
        rd(AOWR_ADDR_STATUS, 32'h2);
        $display("software start test done");
        rst_n <= 1'b0;
        @(posedge core_clk);
        chk(32'({hold_ctrl, clip_out, data_strobe, irq, data_out}), 32'h0);
        rst_n <= 1'b1;
        rd(AOWR_ADDR_CTRL, 32'h1);
        rd(AOWR_ADDR_IRQ_MASK, 32'h0);
        rd(AOWR_ADDR_IRQ_STAT, 32'h0);
        $display("reset test done");
        test_done;
    end
endmodule
